// *** design/packet_buffer_pkg.sv ***
// Purpose: Constants for the packet buffer diagnostic access block
// Assumes: 32-bit AXI4-Lite register bus, 17-bit byte address
// Notes: Printed offsets are byte addresses
package packet_buffer_pkg;
   localparam int ADDR_W = 17;
   localparam logic [16:0] OFF_SAVED_TAIL = 17'h03428;
   localparam logic [16:0] OFF_PKT_COUNT = 17'h03430;
   localparam logic [16:0] OFF_TX_SIZE = 17'h03440;
   localparam logic [16:0] OFF_ACCESS_CTL = 17'h03448;
   localparam logic [16:0] WINDOW_BASE = 17'h10000;
   localparam logic [16:0] WINDOW_LAST = 17'h1fffc;
   localparam int PTR_W = 13;
   localparam int LIVE_TAIL_W = 11;
   localparam logic [12:0] PTR_RESET = 13'h0000;
   localparam logic [12:0] COUNT_RESET = 13'h0000;
   localparam logic [6:0] BUF_KB_FULL = 7'h40;
   localparam logic [6:0] BUF_KB_REDUCED = 7'h28;
   localparam logic [6:0] TX_KB_FULL = 7'h10;
   localparam logic [6:0] TX_KB_REDUCED = 7'h12;
   localparam int QWORDS_PER_KB_SHIFT = 7;
   localparam int MEM_WORDS = 8192;
   localparam int ACCESS_CTL_WIDE_BIT = 0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : packet_buffer_pkg

// *** design/packet_buffer_diag_access.sv ***
// Purpose: Packet buffer memory with diagnostic window and transmit FIFO bookkeeping
// Assumes: One clock, async active-high reset, AXI4-Lite slave for software
// Notes: Memory contents are not cleared by reset; write the window to initialise
`timescale 1ns/1ps

// How it works
// (R1) Thirteen-bit saved copy of transmit tail, reset zero, restorable to the live pointer.
// (R2) Upper bits 31:13 of saved-tail and packet-count registers always read zero.
// (R3) Software writes zeros into those reserved upper bits.
// (R4) Bits 12:0 of packet-count register report queued transmit packets, reset zero.
// (R5) Software leaves saved-tail and packet-count alone during normal operation.
// (R6) Whole packet buffer is readable and writable through the diagnostic window.
// (R7) Window accesses work at 32-bit or 64-bit width.
// (R8) Buffer holds 64 KB, or 40 KB in the reduced variant.
// (R9) Software sets the transmit/receive split; defaults 16/48 KB or 18/22 KB.
// (R10) Receive region sits lowest in the window, transmit region follows it.
// (R11) Full-size default split puts receive below 1C000h and transmit from 1C000h to 1FFFFh.
// (R12) Storage is 64-bit words; pointers count quadwords into their region.
// (R13) Live transmit tail pointer is eleven bits wide.
// (R14) Address bit 2 picks the half for 32-bit access; 64-bit moves the whole word.
module packet_buffer_diag_access
   import packet_buffer_pkg::*;
#(
   parameter bit REDUCED_VARIANT = 1'b0
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic [16:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [16:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic i_tx_pkt_queued,
   input wire logic i_tx_pkt_sent,
   input wire logic i_save_tail,
   input wire logic [10:0] i_live_transmit_tail_pointer,
   output logic o_tail_restore,
   output logic [10:0] o_restore_tail_value,
   output logic [12:0] o_tx_fifo_base
);

   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [5:0] {
      SEL_NONE = 6'h01,
      SEL_TAIL = 6'h02,
      SEL_COUNT = 6'h04,
      SEL_TXSZ = 6'h08,
      SEL_CTL = 6'h10,
      SEL_WIN = 6'h20
   } sel_t;

   localparam logic [6:0] TOTAL_KB = REDUCED_VARIANT ? BUF_KB_REDUCED : BUF_KB_FULL; // (R8)
   localparam logic [6:0] TX_KB_RESET = REDUCED_VARIANT ? TX_KB_REDUCED : TX_KB_FULL; // (R9)
   localparam logic [13:0] CAP_QWORDS = 14'(TOTAL_KB) << QWORDS_PER_KB_SHIFT;
   logic [63:0] mem [MEM_WORDS];
   logic [63:0] mem_q;
   logic [12:0] saved_tail;
   logic [12:0] pkt_count;
   logic [6:0] tx_kb;
   logic wide_access;
   logic [31:0] staged_lo;
   logic [3:0] staged_strb;
   logic [31:0] snap_hi;
   logic rd_busy;
   logic rd_stage;
   sel_t rd_sel;
   logic rd_hi;
   logic rd_err;

   function automatic logic [31:0] merge32(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction : merge32

   function automatic sel_t decode(input logic [16:0] addr);
      sel_t s;
      s = SEL_NONE;
      if (addr >= WINDOW_BASE && addr <= (WINDOW_LAST | 17'h00003)) begin
         if ((14'(addr[15:3])) < CAP_QWORDS) begin
            s = SEL_WIN; // (R6)
         end
      end else if (addr[16:2] == OFF_SAVED_TAIL[16:2]) begin
         s = SEL_TAIL;
      end else if (addr[16:2] == OFF_PKT_COUNT[16:2]) begin
         s = SEL_COUNT;
      end else if (addr[16:2] == OFF_TX_SIZE[16:2]) begin
         s = SEL_TXSZ;
      end else if (addr[16:2] == OFF_ACCESS_CTL[16:2]) begin
         s = SEL_CTL;
      end
      return s;
   endfunction : decode

   ////////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken together, one write in flight
   logic wr_go;
   sel_t aw_sel;
   logic [31:0] tail_merged;
   logic [31:0] count_merged;
   logic [31:0] txsz_merged;
   logic txsz_bad;
   logic wr_err;
   logic mem_wr_en;
   logic [7:0] mem_wr_mask;
   logic [63:0] mem_wr_data;

   assign wr_go = o_s_axi_awready & i_s_axi_awvalid;
   assign aw_sel = decode(i_s_axi_awaddr);
   assign tail_merged = merge32({19'h00000, saved_tail}, i_s_axi_wdata, i_s_axi_wstrb);
   assign count_merged = merge32({19'h00000, pkt_count}, i_s_axi_wdata, i_s_axi_wstrb);
   assign txsz_merged = merge32({25'h0000000, tx_kb}, i_s_axi_wdata, i_s_axi_wstrb);
   // A zero or oversize transmit share would leave no valid region boundary
   assign txsz_bad = (txsz_merged == 32'h00000000) || (txsz_merged > {25'h0000000, TOTAL_KB});
   assign wr_err = (aw_sel == SEL_NONE) || (aw_sel == SEL_TXSZ && txsz_bad);

   always_comb begin
      mem_wr_en = 1'b0;
      mem_wr_mask = 8'h00;
      mem_wr_data = {i_s_axi_wdata, i_s_axi_wdata};
      if (wr_go && aw_sel == SEL_WIN) begin
         if (wide_access && i_s_axi_awaddr[2]) begin
            mem_wr_en = 1'b1; // (R7)
            mem_wr_mask = {i_s_axi_wstrb, staged_strb};
            mem_wr_data = {i_s_axi_wdata, staged_lo};
         end else if (!wide_access) begin
            mem_wr_en = 1'b1;
            mem_wr_mask = i_s_axi_awaddr[2] ? {i_s_axi_wstrb, 4'h0} : {4'h0, i_s_axi_wstrb}; // (R14)
         end
      end
   end

   logic wr_accept;
   assign wr_accept = !o_s_axi_awready && i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid;
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_s_axi_awready <= 1'b0;
         o_s_axi_wready <= 1'b0;
      end else begin
         o_s_axi_awready <= wr_accept;
         o_s_axi_wready <= wr_accept;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         o_s_axi_bvalid <= 1'b1;
         o_s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (i_s_axi_bready) begin
         o_s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Packet buffer storage, 64-bit words, byte-lane writes
   always_ff @(posedge i_ref_clk) begin
      mem_q <= mem[i_s_axi_araddr[15:3]]; // (R6)
      if (mem_wr_en) begin
         for (int b = 0; b < 8; b++) begin
            if (mem_wr_mask[b]) begin
               mem[i_s_axi_awaddr[15:3]][8*b +: 8] <= mem_wr_data[8*b +: 8]; // (R12)
            end
         end
      end
   end

   // Low half of a 64-bit write waits here for its high half
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         staged_lo <= 32'h00000000;
         staged_strb <= 4'h0;
      end else if (wr_go && aw_sel == SEL_WIN && wide_access && !i_s_axi_awaddr[2]) begin
         staged_lo <= i_s_axi_wdata; // (R7)
         staged_strb <= i_s_axi_wstrb;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit FIFO bookkeeping
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         saved_tail <= PTR_RESET; // (R1)
      end else if (i_save_tail) begin
         // Hardware capture wins over a software write in the same cycle
         saved_tail <= {2'h0, i_live_transmit_tail_pointer}; // (R1) (R13)
      end else if (wr_go && aw_sel == SEL_TAIL) begin
         saved_tail <= tail_merged[12:0]; // (R1)
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_tail_restore <= 1'b0;
         o_restore_tail_value <= 11'h000;
      end else begin
         o_tail_restore <= wr_go && aw_sel == SEL_TAIL; // (R1)
         o_restore_tail_value <= tail_merged[10:0]; // (R13)
      end
   end

   logic [12:0] count_base;
   assign count_base = (wr_go && aw_sel == SEL_COUNT) ? count_merged[12:0] : pkt_count;
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pkt_count <= COUNT_RESET; // (R4)
      end else begin
         // Queue and send events still count when software writes in the same cycle
         pkt_count <= count_base + 13'(i_tx_pkt_queued) - 13'(i_tx_pkt_sent); // (R4)
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Split and access mode
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tx_kb <= TX_KB_RESET; // (R9)
      end else if (wr_go && aw_sel == SEL_TXSZ && !txsz_bad) begin
         tx_kb <= txsz_merged[6:0]; // (R9)
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wide_access <= 1'b0;
      end else if (wr_go && aw_sel == SEL_CTL && i_s_axi_wstrb[0]) begin
         wide_access <= i_s_axi_wdata[ACCESS_CTL_WIDE_BIT]; // (R7)
      end
   end

   // Receive region first, transmit region from here to the top
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_tx_fifo_base <= 13'h0000;
      end else begin
         o_tx_fifo_base <= 13'(CAP_QWORDS - (14'(tx_kb) << QWORDS_PER_KB_SHIFT)); // (R10) (R11)
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read channel: fixed two-cycle latency after the address is taken
   logic rd_go;
   assign rd_go = o_s_axi_arready & i_s_axi_arvalid;
   // One read in flight: no new address until the data has been taken
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_s_axi_arready <= 1'b0;
         rd_busy <= 1'b0;
      end else begin
         o_s_axi_arready <= !o_s_axi_arready && i_s_axi_arvalid && !rd_busy;
         if (rd_go) begin
            rd_busy <= 1'b1;
         end else if (o_s_axi_rvalid && i_s_axi_rready) begin
            rd_busy <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rd_stage <= 1'b0;
         rd_sel <= SEL_NONE;
         rd_hi <= 1'b0;
         rd_err <= 1'b0;
      end else begin
         rd_stage <= rd_go;
         if (rd_go) begin
            rd_sel <= decode(i_s_axi_araddr);
            rd_hi <= i_s_axi_araddr[2];
            rd_err <= decode(i_s_axi_araddr) == SEL_NONE;
         end
      end
   end

   // High half kept from the low-half read so a 64-bit read is one coherent word
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         snap_hi <= 32'h00000000;
      end else if (rd_stage && rd_sel == SEL_WIN && wide_access && !rd_hi) begin
         snap_hi <= mem_q[63:32]; // (R7)
      end
   end

   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h00000000;
      unique case (rd_sel)
         SEL_TAIL: next_rdata = {19'h00000, saved_tail}; // (R2)
         SEL_COUNT: next_rdata = {19'h00000, pkt_count}; // (R2) (R4)
         SEL_TXSZ: next_rdata = {25'h0000000, tx_kb};
         SEL_CTL: next_rdata = {31'h00000000, wide_access};
         SEL_WIN: begin
            if (!rd_hi) begin
               next_rdata = mem_q[31:0]; // (R14)
            end else if (wide_access) begin
               next_rdata = snap_hi; // (R7)
            end else begin
               next_rdata = mem_q[63:32]; // (R14)
            end
         end
         SEL_NONE: next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= 32'h00000000;
         o_s_axi_rresp <= RESP_OKAY;
      end else if (rd_stage) begin
         o_s_axi_rvalid <= 1'b1;
         o_s_axi_rdata <= next_rdata;
         o_s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (i_s_axi_rready) begin
         o_s_axi_rvalid <= 1'b0;
      end
   end

endmodule : packet_buffer_diag_access

// *** dv/packet_buffer_chk.sv ***
// Purpose: Port checks for packet_buffer_diag_access
// Assumes: One clock, async active-high reset
// Notes: Window contents judged by the bench
`timescale 1ns/1ps
module packet_buffer_chk
   import packet_buffer_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic [16:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   input wire logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic o_s_axi_wready,
   input wire logic [1:0] o_s_axi_bresp,
   input wire logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [16:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   input wire logic o_s_axi_arready,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic [1:0] o_s_axi_rresp,
   input wire logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic o_tail_restore,
   input wire logic [10:0] o_restore_tail_value
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   logic aw_hs;
   logic ar_hs;
   assign aw_hs = o_s_axi_awready && i_s_axi_awvalid;
   assign ar_hs = o_s_axi_arready && i_s_axi_arvalid;
   ////////////////////////////////////////////////////////////////////////////////
   a_aw_w_paired: assert property (o_s_axi_awready == o_s_axi_wready)
      else $error("awready and wready differ");
   a_bresp_after_aw: assert property (aw_hs |=> o_s_axi_bvalid && !o_s_axi_awready)
      else $error("write response late");
   a_bvalid_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready
      |=> o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("bvalid dropped");
   a_rvalid_two_late: assert property (ar_hs |-> !o_s_axi_rvalid ##1 !o_s_axi_rvalid
      ##1 o_s_axi_rvalid) else $error("read data timing");
   a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready
      |=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("rdata moved");
   a_upper_bits_zero: assert property (ar_hs
      && (i_s_axi_araddr == OFF_SAVED_TAIL || i_s_axi_araddr == OFF_PKT_COUNT)
      |-> ##2 o_s_axi_rdata[31:13] == 19'h0) else $error("reserved bits set");
   a_restore_on_write: assert property (aw_hs && i_s_axi_wstrb == 4'hf
      && i_s_axi_awaddr == OFF_SAVED_TAIL |=> o_tail_restore
      && o_restore_tail_value == $past(i_s_axi_wdata[10:0])) else $error("no restore");
   a_restore_single: assert property (o_tail_restore |=> !o_tail_restore)
      else $error("restore too long");
   a_unmapped_err: assert property (ar_hs && i_s_axi_araddr == 17'h00100
      |-> ##2 o_s_axi_rresp == RESP_SLVERR && o_s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   c_write: cover property (aw_hs);
   c_read: cover property (ar_hs);
   c_restore: cover property (o_tail_restore);
endmodule : packet_buffer_chk
bind packet_buffer_diag_access packet_buffer_chk u_chk (.i_ref_clk, .i_sys_rst,
   .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb,
   .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr,
   .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
   .i_s_axi_rready, .o_tail_restore, .o_restore_tail_value);

// *** dv/tb_packet_buffer_diag_access.sv ***
// Purpose: Self-checking bench for packet_buffer_diag_access
// Assumes: Full-size variant, AXI4-Lite master in the bench
// Notes: Window words written before they are read
`timescale 1ns/1ps
module tb_packet_buffer_diag_access
   import packet_buffer_pkg::*;
;
   logic i_ref_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [16:0] i_s_axi_awaddr = 17'h0;
   logic i_s_axi_awvalid = 1'b0;
   logic [31:0] i_s_axi_wdata = 32'h0;
   logic [3:0] i_s_axi_wstrb = 4'hf;
   logic i_s_axi_wvalid = 1'b0;
   logic i_s_axi_bready = 1'b0;
   logic [16:0] i_s_axi_araddr = 17'h0;
   logic i_s_axi_arvalid = 1'b0;
   logic i_s_axi_rready = 1'b0;
   logic i_tx_pkt_queued = 1'b0;
   logic i_tx_pkt_sent = 1'b0;
   logic i_save_tail = 1'b0;
   logic [10:0] i_live_transmit_tail_pointer = 11'h0;
   logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
   logic [31:0] o_s_axi_rdata;
   logic o_tail_restore;
   logic [10:0] o_restore_tail_value;
   logic [12:0] o_tx_fifo_base;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;
   always #2 i_ref_clk = ~i_ref_clk;
   packet_buffer_diag_access uut (.i_ref_clk, .i_sys_rst, .i_s_axi_awaddr, .i_s_axi_awvalid,
      .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
      .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
      .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
      .i_tx_pkt_queued, .i_tx_pkt_sent, .i_save_tail, .i_live_transmit_tail_pointer,
      .o_tail_restore, .o_restore_tail_value, .o_tx_fifo_base);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [16:0] a, input logic [31:0] d, input logic [1:0] r);
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= d;
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid <= 1'b1;
      i_s_axi_bready <= 1'b1;
      do @(posedge i_ref_clk); while (o_s_axi_awready !== 1'b1);
      i_s_axi_awvalid <= 1'b0;
      i_s_axi_wvalid <= 1'b0;
      do @(posedge i_ref_clk); while (o_s_axi_bvalid !== 1'b1);
      i_s_axi_bready <= 1'b0;
      check({30'h0, o_s_axi_bresp}, {30'h0, r});
      repeat (2) @(posedge i_ref_clk);
   endtask : wr
   task automatic rd(input logic [16:0] a, input logic [31:0] d, input logic [1:0] r);
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_rready <= 1'b1;
      do @(posedge i_ref_clk); while (o_s_axi_arready !== 1'b1);
      i_s_axi_arvalid <= 1'b0;
      do @(posedge i_ref_clk); while (o_s_axi_rvalid !== 1'b1);
      i_s_axi_rready <= 1'b0;
      check({30'h0, o_s_axi_rresp}, {30'h0, r});
      check(o_s_axi_rdata, d);
      @(posedge i_ref_clk);
   endtask : rd
   task automatic pulse(input logic q, input logic s, input logic t);
      i_tx_pkt_queued <= q;
      i_tx_pkt_sent <= s;
      i_save_tail <= t;
      @(posedge i_ref_clk);
      i_tx_pkt_queued <= 1'b0;
      i_tx_pkt_sent <= 1'b0;
      i_save_tail <= 1'b0;
      @(posedge i_ref_clk);
   endtask : pulse
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults();
      rd(OFF_SAVED_TAIL, 32'h0, RESP_OKAY);
      rd(OFF_PKT_COUNT, 32'h0, RESP_OKAY);
      rd(OFF_TX_SIZE, 32'h10, RESP_OKAY);
      check({19'h0, o_tx_fifo_base}, 32'h1800);
   endtask : t_defaults
   task automatic t_saved_tail();
      wr(OFF_SAVED_TAIL, 32'h00001abc, RESP_OKAY);
      rd(OFF_SAVED_TAIL, 32'h1abc, RESP_OKAY);
      i_live_transmit_tail_pointer <= 11'h5a5;
      pulse(1'b0, 1'b0, 1'b1);
      rd(OFF_SAVED_TAIL, 32'h5a5, RESP_OKAY);
      i_s_axi_wstrb <= 4'h2;
      wr(OFF_SAVED_TAIL, 32'h00000300, RESP_OKAY);
      i_s_axi_wstrb <= 4'hf;
      rd(OFF_SAVED_TAIL, 32'h3a5, RESP_OKAY);
   endtask : t_saved_tail
   task automatic t_pkt_count();
      repeat (3) pulse(1'b1, 1'b0, 1'b0);
      pulse(1'b1, 1'b1, 1'b0);
      pulse(1'b0, 1'b1, 1'b0);
      rd(OFF_PKT_COUNT, 32'h2, RESP_OKAY);
   endtask : t_pkt_count
   task automatic t_window();
      logic [16:0] a [3] = '{WINDOW_BASE, 17'h1bffc, WINDOW_LAST};
      for (int i = 0; i < 3; i++) wr(a[i], {15'h5a5a, a[i]}, RESP_OKAY);
      for (int i = 0; i < 3; i++) rd(a[i], {15'h5a5a, a[i]}, RESP_OKAY);
   endtask : t_window
   task automatic t_wide();
      wr(17'h1c008, 32'h0, RESP_OKAY);
      wr(17'h1c00c, 32'h0, RESP_OKAY);
      wr(OFF_ACCESS_CTL, 32'h1, RESP_OKAY);
      wr(17'h1c008, 32'h11111111, RESP_OKAY);
      rd(17'h1c008, 32'h0, RESP_OKAY);
      wr(17'h1c00c, 32'h22222222, RESP_OKAY);
      rd(17'h1c008, 32'h11111111, RESP_OKAY);
      rd(17'h1c00c, 32'h22222222, RESP_OKAY);
      wr(OFF_ACCESS_CTL, 32'h0, RESP_OKAY);
   endtask : t_wide
   task automatic t_split();
      wr(OFF_TX_SIZE, 32'h20, RESP_OKAY);
      check({19'h0, o_tx_fifo_base}, 32'h1000);
      wr(OFF_TX_SIZE, 32'h0, RESP_SLVERR);
      rd(OFF_TX_SIZE, 32'h20, RESP_OKAY);
      wr(OFF_TX_SIZE, 32'h10, RESP_OKAY);
      check({19'h0, o_tx_fifo_base}, 32'h1800);
   endtask : t_split
   task automatic t_unmapped();
      wr(17'h00100, 32'h0, RESP_SLVERR);
      rd(17'h00100, 32'h0, RESP_SLVERR);
   endtask : t_unmapped
   // Late bready and rready, so the answers must stand while unaccepted
   task automatic t_late_ready();
      i_s_axi_awaddr <= OFF_TX_SIZE;
      i_s_axi_wdata <= 32'h00000010;
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid <= 1'b1;
      do @(posedge i_ref_clk); while (o_s_axi_awready !== 1'b1);
      i_s_axi_awvalid <= 1'b0;
      i_s_axi_wvalid <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      i_s_axi_bready <= 1'b1;
      do @(posedge i_ref_clk); while (o_s_axi_bvalid !== 1'b1);
      i_s_axi_bready <= 1'b0;
      check({30'h0, o_s_axi_bresp}, {30'h0, RESP_OKAY});
      i_s_axi_araddr <= OFF_TX_SIZE;
      i_s_axi_arvalid <= 1'b1;
      do @(posedge i_ref_clk); while (o_s_axi_arready !== 1'b1);
      i_s_axi_arvalid <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      i_s_axi_rready <= 1'b1;
      do @(posedge i_ref_clk); while (o_s_axi_rvalid !== 1'b1);
      i_s_axi_rready <= 1'b0;
      check(o_s_axi_rdata, 32'h00000010);
      @(posedge i_ref_clk);
   endtask : t_late_ready
   initial begin
      repeat (10) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_ref_clk);
      t_defaults();
      t_saved_tail();
      t_pkt_count();
      t_window();
      t_wide();
      t_split();
      t_unmapped();
      t_late_ready();
      tally_and_finish();
   end
endmodule : tb_packet_buffer_diag_access
